// File: rtl/acc_clkdiv.sv
// converter clock divider producing one tick per converter clock period
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv
	import acc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       clr_i,
	input  wire logic       en_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [5:0] mask;

	// divide ratio mask; the undefined code runs as the slowest ratio
	always_comb begin
		unique case (sel_i)
			3'h0: mask = 6'h00;
			3'h1: mask = 6'h01;
			3'h2: mask = 6'h03;
			3'h3: mask = 6'h07;
			3'h4: mask = 6'h0F;
			3'h5: mask = 6'h1F;
			default: mask = 6'h3F;
		endcase
		tick_o = en_i & ~clr_i & ((cnt_q & mask) == mask);
		if (clr_i) begin
			cnt_d = 6'h00;
		end else if (en_i) begin
			cnt_d = cnt_q + 6'h01;
		end else begin
			cnt_d = cnt_q;
		end
	end

	// counter register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// File: rtl/acc_defs.svh
// register map, field positions, reset values and timing counts
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// register byte offsets
`define ACC_OFF_CTRL0      8'h00
`define ACC_OFF_CTRL1      8'h04
`define ACC_OFF_AEN_LO     8'h08
`define ACC_OFF_AEN_HI     8'h0C
`define ACC_OFF_IRQ        8'h10
`define ACC_OFF_RESULT     8'h14

// conv_control_reg0 fields
`define ACC_C0_START       7
`define ACC_C0_BUSY        6
`define ACC_C0_PWR_OFF     5
// conv_control_reg1 fields
`define ACC_C1_REF_SEL     3
`define ACC_C1_DIV_HI      2
`define ACC_C1_DIV_LO      0
// interrupt register fields
`define ACC_IRQ_FLAG       0
`define ACC_IRQ_EN         1

// reset values
`define ACC_RST_PWR_OFF    1'b1
`define ACC_RST_DIV        3'h0
`define ACC_RST_AEN        10'h3FF

// conversion length in converter clock periods, minus one
`define ACC_CONV_LAST      4'hF

// converter clock period window and system clock
`define ACC_CLK_NS         20
`define ACC_TADCK_MIN_NS   500
`define ACC_TADCK_MAX_NS   10000
`define ACC_TADCK_MIN_CYC  ((`ACC_TADCK_MIN_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_TADCK_MAX_CYC  (`ACC_TADCK_MAX_NS / `ACC_CLK_NS)

`endif

// File: rtl/acc_pinmux.sv
// per-pin steering between analog input and digital port functions
`timescale 1ns/1ps
`default_nettype none
module acc_pinmux
	import acc_pkg::*;
(
	input  wire logic [9:0] analog_en_i,
	input  wire logic [9:0] port_oe_i,
	input  wire logic [9:0] port_pull_i,
	input  wire logic       ref_sel_i,
	output logic      [9:0] pin_oe_o,
	output logic      [9:0] pin_pull_o,
	output logic      [9:0] pin_dig_en_o,
	output logic      [9:0] pin_ain_o,
	output logic            vref_pin_o,
	output logic            vref_other_en_o
);
	genvar i;
	// an analog pin drops its driver, pull-high and digital path
	for (i = 0; i < 10; i++) begin : g_pin
		assign pin_ain_o[i]    = analog_en_i[i];
		assign pin_oe_o[i]     = port_oe_i[i] & ~analog_en_i[i];
		assign pin_pull_o[i]   = port_pull_i[i] & ~analog_en_i[i];
		assign pin_dig_en_o[i] = ~analog_en_i[i];
	end

	// reference pin takes over from its shared functions
	assign vref_pin_o      = ref_sel_i;
	assign vref_other_en_o = ~ref_sel_i;
endmodule
`default_nettype wire

// File: rtl/acc_pkg.sv
// types shared by the conversion control block
package acc_pkg;
	typedef enum logic [2:0] {
		ACC_IDLE  = 3'b001,
		ACC_RESET = 3'b010,
		ACC_CONV  = 3'b100
	} acc_state_t;
endpackage

// File: rtl/acc_top.sv
// conversion control: wishbone registers, start sequencing, pin steering
//
// Overview of operation
// R1: start conversion on full high-low start pulse
// R2: start held high resets converter, busy high
// R3: busy flag clears itself when conversion ends
// R4: conversion end sets request, enabled interrupt asserts
// R5: three-bit divider selects system clock ratio
// R6: software keeps converter clock in permitted window
// R7: converter powered only while power-off bit low
// R8: software waits settling time after power on
// R9: reference select picks rail or reference pin
// R10: analog enable makes pin converter input
// R11: analog pin drops its pull-high resistor
// R12: analog enable overrides port direction setting
// R13: conversion lasts sixteen converter clock periods
// R14: twelve-bit result captured at conversion end
// R15: busy high through conversion, falls with request
//
// The register offsets and register access over Wishbone were left to the implementer.
`include "acc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module acc_top
	import acc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             conv_rst_o,
	output logic             conv_pd_o,
	output logic             conv_start_o,
	output logic             conv_tick_o,
	output logic             ref_sel_o,
	input  wire logic [11:0] conv_result_i,
	output logic             irq_o,
	input  wire logic [9:0]  port_oe_i,
	input  wire logic [9:0]  port_pull_i,
	output logic      [9:0]  pin_oe_o,
	output logic      [9:0]  pin_pull_o,
	output logic      [9:0]  pin_dig_en_o,
	output logic      [9:0]  pin_ain_o,
	output logic             vref_pin_o,
	output logic             vref_other_en_o
);
	acc_state_t  state_q;
	acc_state_t  state_d;
	logic        start_q;
	logic        start_d;
	logic        pwr_off_q;
	logic        pwr_off_d;
	logic [2:0]  div_q;
	logic [2:0]  div_d;
	logic        ref_q;
	logic        ref_d;
	logic [9:0]  aen_q;
	logic [9:0]  aen_d;
	logic        irq_en_q;
	logic        irq_en_d;
	logic        irq_q;
	logic        irq_d;
	logic        busy_q;
	logic        busy_d;
	logic [3:0]  tcnt_q;
	logic [3:0]  tcnt_d;
	logic [11:0] result_q;
	logic [11:0] result_d;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] dat_q;
	logic [31:0] dat_d;

	logic        wb_req;
	logic        wb_wr;
	logic        tick;
	logic        div_clr;
	logic        done;

	// bus strobes: a write takes effect at the edge where ack is seen
	assign wb_req = cyc_i & stb_i;
	assign wb_wr  = wb_req & we_i & ack_q & sel_i[0];

	// converter clock divider, held clear outside a conversion
	assign div_clr = (state_q != ACC_CONV);

	acc_clkdiv u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (div_clr),
		.en_i   (~pwr_off_q), // see R7
		.sel_i  (div_q),      // see R5
		.tick_o (tick)
	);

	// pin and reference steering
	acc_pinmux u_pins (
		.analog_en_i     (aen_q),
		.port_oe_i       (port_oe_i),
		.port_pull_i     (port_pull_i),
		.ref_sel_i       (ref_q),
		.pin_oe_o        (pin_oe_o),     // see R10, R12
		.pin_pull_o      (pin_pull_o),   // see R11
		.pin_dig_en_o    (pin_dig_en_o), // see R10
		.pin_ain_o       (pin_ain_o),
		.vref_pin_o      (vref_pin_o),   // see R9
		.vref_other_en_o (vref_other_en_o)
	);

	// last converter period of a valid conversion
	assign done = (state_q == ACC_CONV) & tick & !start_q & !pwr_off_q
		& (tcnt_q == `ACC_CONV_LAST); // see R13

	// software-written control registers
	always_comb begin
		start_d   = start_q;
		pwr_off_d = pwr_off_q;
		div_d     = div_q;
		ref_d     = ref_q;
		aen_d     = aen_q;
		irq_en_d  = irq_en_q;
		if (wb_wr) begin
			unique case (adr_i)
				`ACC_OFF_CTRL0: begin
					start_d   = dat_i[`ACC_C0_START];
					pwr_off_d = dat_i[`ACC_C0_PWR_OFF];
				end
				`ACC_OFF_CTRL1: begin
					div_d = dat_i[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO];
					ref_d = dat_i[`ACC_C1_REF_SEL];
				end
				`ACC_OFF_AEN_LO: aen_d[7:0] = dat_i[7:0];
				`ACC_OFF_AEN_HI: aen_d[9:8] = dat_i[1:0];
				`ACC_OFF_IRQ:    irq_en_d = dat_i[`ACC_IRQ_EN];
				default: ;
			endcase
		end
	end

	// control register state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_q   <= 1'b0;
			pwr_off_q <= `ACC_RST_PWR_OFF;
			div_q     <= `ACC_RST_DIV;
			ref_q     <= 1'b0;
			aen_q     <= `ACC_RST_AEN;
			irq_en_q  <= 1'b0;
		end else begin
			start_q   <= start_d;
			pwr_off_q <= pwr_off_d;
			div_q     <= div_d;
			ref_q     <= ref_d;
			aen_q     <= aen_d;
			irq_en_q  <= irq_en_d;
		end
	end

	// start sequencing: raise resets, fall starts, sixteen periods run
	always_comb begin
		state_d  = state_q;
		busy_d   = busy_q;
		tcnt_d   = tcnt_q;
		result_d = result_q;
		unique case (state_q)
			ACC_IDLE: begin
				if (start_q) begin
					state_d = ACC_RESET;
					busy_d  = 1'b1; // see R2
				end
			end
			ACC_RESET: begin
				busy_d = 1'b1; // see R2
				tcnt_d = 4'h0;
				if (!start_q) begin
					state_d = pwr_off_q ? ACC_IDLE : ACC_CONV; // see R1
				end
			end
			ACC_CONV: begin
				if (start_q) begin
					state_d = ACC_RESET; // see R2
					busy_d  = 1'b1;
				end else if (pwr_off_q) begin
					state_d = ACC_IDLE; // see R7
				end else if (done) begin
					state_d  = ACC_IDLE;
					busy_d   = 1'b0;          // see R3, R15
					result_d = conv_result_i; // see R14
				end else if (tick) begin
					tcnt_d = tcnt_q + 4'h1; // see R13
				end
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q  <= ACC_IDLE;
			busy_q   <= 1'b0;
			tcnt_q   <= 4'h0;
			result_q <= 12'h000;
		end else begin
			state_q  <= state_d;
			busy_q   <= busy_d;
			tcnt_q   <= tcnt_d;
			result_q <= result_d;
		end
	end

	// request flag: completion wins over a write-one clear
	always_comb begin
		irq_d = irq_q;
		if (wb_wr && adr_i == `ACC_OFF_IRQ && dat_i[`ACC_IRQ_FLAG]) begin
			irq_d = 1'b0;
		end
		if (done) begin
			irq_d = 1'b1; // see R4
		end
	end

	// request flag register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// wishbone answer: one wait cycle, read data captured with ack
	always_comb begin
		ack_d = wb_req & ~ack_q;
		dat_d = dat_q;
		if (wb_req && !ack_q) begin
			dat_d = 32'h0000_0000;
			unique case (adr_i)
				`ACC_OFF_CTRL0: begin
					dat_d[`ACC_C0_START]   = start_q;
					dat_d[`ACC_C0_BUSY]    = busy_q;
					dat_d[`ACC_C0_PWR_OFF] = pwr_off_q;
				end
				`ACC_OFF_CTRL1: begin
					dat_d[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO] = div_q;
					dat_d[`ACC_C1_REF_SEL] = ref_q;
				end
				`ACC_OFF_AEN_LO: dat_d[7:0] = aen_q[7:0];
				`ACC_OFF_AEN_HI: dat_d[1:0] = aen_q[9:8];
				`ACC_OFF_IRQ: begin
					dat_d[`ACC_IRQ_FLAG] = irq_q;
					dat_d[`ACC_IRQ_EN]   = irq_en_q;
				end
				`ACC_OFF_RESULT: dat_d[11:0] = result_q;
				default: ;
			endcase
		end
	end

	// bus answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// outputs toward the bus and the analog core
	assign ack_o        = ack_q;
	assign dat_o        = dat_q;
	assign conv_rst_o   = (state_q == ACC_RESET); // see R2
	assign conv_pd_o    = pwr_off_q;              // see R7
	assign conv_start_o = (state_q == ACC_RESET) & !start_q & !pwr_off_q;
	assign conv_tick_o  = tick;
	assign ref_sel_o    = ref_q;                  // see R9
	assign irq_o        = irq_q & irq_en_q;       // see R4

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence start_raised_s;
		(state_q == ACC_IDLE || state_q == ACC_CONV) && start_q;
	endsequence

	sequence pulse_done_s;
		state_q == ACC_RESET && !start_q && !pwr_off_q;
	endsequence

	start_reset_a: assert property (start_raised_s |=> // see R2
		state_q == ACC_RESET && busy_q ##1 busy_q && conv_rst_o)
		else $error("start high did not reset converter");
	pulse_start_a: assert property (pulse_done_s |=> // see R1
		state_q == ACC_CONV && busy_q && tcnt_q == 4'h0)
		else $error("start pulse did not begin conversion");
	done_clear_a: assert property (done |=> !busy_q && // see R3
		state_q == ACC_IDLE)
		else $error("busy flag not cleared at conversion end");
	irq_set_a: assert property (done |=> irq_q && // see R4
		(irq_o == irq_en_q))
		else $error("interrupt request not raised at end");
	div_rate_a: assert property (state_q == ACC_CONV && // see R5
		div_q == 3'h0 && !pwr_off_q && $past(state_q) == ACC_CONV
		|-> tick)
		else $error("undivided converter clock missed a tick");
	div_two_a: assert property (state_q == ACC_CONV && // see R5
		div_q == 3'h1 && !pwr_off_q && tick |=> !tick)
		else $error("divide by two ticked twice in a row");
	power_off_a: assert property (pwr_off_q |-> conv_pd_o && // see R7
		!tick && !conv_start_o)
		else $error("converter active while powered off");
	ref_pin_a: assert property (ref_sel_o |-> vref_pin_o && // see R9
		!vref_other_en_o)
		else $error("reference pin still shared");
	pin_analog_a: assert property ((aen_q & (pin_oe_o | pin_pull_o // see R10
		| pin_dig_en_o)) == 10'h000)
		else $error("analog pin kept digital function");
	conv_len_a: assert property (done |-> tcnt_q == 4'hF && // see R13
		$past(state_q, 1) == ACC_CONV)
		else $error("conversion length not sixteen periods");
	result_cap_a: assert property (done |=> // see R14
		result_q == $past(conv_result_i))
		else $error("result not captured at conversion end");
	busy_conv_a: assert property (state_q == ACC_CONV |-> busy_q) // see R15
		else $error("busy low during conversion");
endmodule
`default_nettype wire

// File: verification/acc_core_model.sv
// behavioural converter core that hands back a fresh code per conversion
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
	input  wire logic        clk_i,
	input  wire logic        conv_rst_i,
	input  wire logic        conv_pd_i,
	input  wire logic        conv_start_i,
	output logic      [11:0] result_o
);
	logic [11:0] val_q;
	initial val_q = 12'h0ff;
	// a new code is prepared on each start pulse
	always @(posedge clk_i) begin
		if (conv_start_i) begin
			val_q <= val_q + 12'h111;
		end
	end
	// a held or unpowered core shows no valid code
	assign result_o = (conv_rst_i || conv_pd_i) ? ~val_q : val_q;
endmodule
`default_nettype wire

// File: verification/tb_acc_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_acc_top;
	import acc_pkg::*;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
	logic        conv_rst_o, conv_pd_o, conv_start_o, conv_tick_o;
	logic        ref_sel_o, vref_pin_o, vref_other_en_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [11:0] conv_result_i, exp_res;
	logic [9:0]  port_oe_i, port_pull_i, pin_oe_o, pin_pull_o;
	logic [9:0]  pin_dig_en_o, pin_ain_o;
	int          err_total, compares, n, ticks;

	acc_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .conv_rst_o, .conv_pd_o, .conv_start_o,
		.conv_tick_o, .ref_sel_o, .conv_result_i, .irq_o, .port_oe_i,
		.port_pull_i, .pin_oe_o, .pin_pull_o, .pin_dig_en_o, .pin_ain_o,
		.vref_pin_o, .vref_other_en_o);
	acc_core_model core (.clk_i, .conv_rst_i(conv_rst_o),
		.conv_pd_i(conv_pd_o), .conv_start_i(conv_start_o),
		.result_o(conv_result_i));

	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk(32'(k), 32'h0000_0000);
			end_sim();
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask

	// main sequence
	initial begin
		{cyc_i, stb_i, we_i} = 3'b000;
		adr_i = 8'h00;
		sel_i = 4'h1;
		dat_i = 32'h0000_0000;
		port_oe_i = 10'h155;
		port_pull_i = 10'h2aa;
		exp_res = 12'h210;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h0000_0020);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_00ff);
		rd(8'h0c, 32'h0000_0003);
		rd(8'h10, 32'h0000_0000);
		wr(8'h18, 32'h0000_00ff);
		rd(8'h18, 32'h0000_0000);
		chk(32'(conv_pd_o), 32'h0000_0001);
		chk(32'(pin_oe_o), 32'h0000_0000);
		chk(32'(pin_pull_o), 32'h0000_0000);
		$display("test reset done");
		wr(8'h08, 32'h0000_000f);
		wr(8'h0c, 32'h0000_0002);
		wr(8'h04, 32'h0000_0008);
		@(negedge clk_i);
		chk(32'(pin_ain_o), 32'h0000_020f);
		chk(32'(pin_dig_en_o), 32'h0000_01f0);
		chk(32'(pin_oe_o), 32'h0000_0150);
		chk(32'(pin_pull_o), 32'h0000_00a0);
		chk(32'({ref_sel_o, vref_pin_o, vref_other_en_o}), 32'h0000_0006);
		$display("test pins done");
		wr(8'h10, 32'h0000_0002);
		// all codes, the undefined one runs as the slowest ratio
		for (int d = 0; d < 8; d++) begin
			wr(8'h04, 32'(d));
			wr(8'h00, 32'h0000_0000);
			repeat (20) @(posedge clk_i);
			chk(32'(conv_pd_o), 32'h0000_0000);
			wr(8'h00, 32'h0000_0080);
			rd(8'h00, 32'h0000_00c0);
			chk(32'(conv_rst_o), 32'h0000_0001);
			wr(8'h00, 32'h0000_0000);
			n = 0;
			while (conv_start_o !== 1'b1 && n < 50) begin
				@(negedge clk_i);
				n++;
			end
			chk(32'(conv_start_o), 32'h0000_0001);
			if (n >= 50) begin
				end_sim();
			end
			n = 0;
			ticks = 0;
			do begin
				@(negedge clk_i);
				if (irq_o === 1'b1)
					break;
				n++;
				ticks += int'(conv_tick_o === 1'b1);
			end while (n < 1200);
			chk(32'(n), 32'h0000_0010 << ((d == 7) ? 6 : d));
			chk(32'(ticks), 32'h0000_0010);
			if (n >= 1200)
				end_sim();
			rd(8'h00, 32'h0000_0000);
			rd(8'h10, 32'h0000_0003);
			rd(8'h14, 32'(exp_res));
			exp_res += 12'h111;
			wr(8'h10, 32'h0000_0003);
			rd(8'h10, 32'h0000_0002);
			chk(32'(irq_o), 32'h0000_0000);
		end
		$display("test conv done");
		// 640 ns converter clock, inside the permitted window
		wr(8'h04, 32'h0000_0005);
		wr(8'h00, 32'h0000_0080);
		wr(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_0080);
		rd(8'h00, 32'h0000_00c0);
		chk(32'(conv_rst_o), 32'h0000_0001);
		wr(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_0020);
		repeat (1100) @(posedge clk_i);
		rd(8'h10, 32'h0000_0002);
		chk(32'(conv_pd_o), 32'h0000_0001);
		$display("test abort done");
		end_sim();
	end
endmodule
`default_nettype wire
